// ===== rtl/pin_ctrl_pkg.sv
// package: constants and carrier types for the serial port pin control block
package pin_ctrl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 25;
    localparam int RESET_MIN_NS    = 40;
    localparam int RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVERSAMPLE      = 16;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int MCR_IR_BIT      = 6;
    localparam int MCR_OP1_BIT     = 2;
    localparam int MCR_OP2_BIT     = 3;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic TX_IDLE_NORMAL = 1'b1;
    localparam logic TX_IDLE_IR     = 1'b0;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       bus_style_select;
        logic       pc_decode_select_n;
        logic       infrared_startup_enable;
        logic       rclk;
        logic       rx;
    } pins_in_type;

    typedef struct packed {
        logic       write_en;
        logic [7:0] modem_control_register;
        logic       div_write_en;
        logic [15:0] divisor;
    } sw_ctrl_type;

    typedef enum logic [1:0] {
        BUS_SEPARATE,
        BUS_COMBINED,
        BUS_PC
    } bus_mode_type;

endpackage

// ===== rtl/pin_sync.sv
// two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             ref_clk,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // no reset: reset itself passes through here
    always_ff @(posedge ref_clk) begin
        meta_ff <= d;
        sync_ff <= meta_ff;
    end

    assign q = sync_ff;
endmodule

// ===== rtl/uart_mode_reset_clock_pins.sv
// pin-level mode, reset, clock steering and output control of the serial port
`timescale 1ns/1ps
module uart_mode_reset_clock_pins
    import pin_ctrl_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        reset_pin,
    // configuration pins
    input  wire pins_in_type pins,
    // host strobes
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        chip_select_n,
    input  wire logic        printer_port_one,
    // software control
    input  wire sw_ctrl_type sw,
    // transmit path from the shifter
    input  wire logic        tx_data,
    input  wire logic        tx_active,
    // outputs
    output logic             ref_clock_out,
    output logic             baud_clock_out_n,
    output logic             drive_disable_n,
    output logic             general_output_one_n,
    output logic             general_output_two_n,
    output logic             tx_out,
    output logic             rx_sample_tick,
    output logic             rx_data,
    output logic             onchip_decode_en,
    output logic             infrared_mode,
    output bus_mode_type     bus_mode
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [8:0] raw_in;
    logic [8:0] syn_in;
    logic       s_style;
    logic       s_pcsel_n;
    logic       s_infrared_startup_enable;
    logic       s_rclk;
    logic       s_rx;
    logic       s_rst_pin;
    logic       s_rd_n;
    logic       s_wr_n;
    logic       s_cs_n;

    assign raw_in = {pins.bus_style_select, pins.pc_decode_select_n,
                     pins.infrared_startup_enable, pins.rclk, pins.rx,
                     reset_pin, read_strobe_n, write_strobe_n, chip_select_n};

    pin_sync #(.WIDTH(9)) u_sync (
        .ref_clk (ref_clk),
        .d       (raw_in),
        .q       (syn_in)
    );

    assign {s_style, s_pcsel_n, s_infrared_startup_enable, s_rclk, s_rx, s_rst_pin, s_rd_n, s_wr_n, s_cs_n} = syn_in;

    // ------------------------------------------------------------
    // mode decode and reset polarity
    // ------------------------------------------------------------
    logic pc_mode;
    logic pin_reset_act;
    logic rst_any;
    logic host_read;

    assign pc_mode  = ~s_pcsel_n;
    assign onchip_decode_en = pc_mode;
    assign bus_mode = pc_mode ? BUS_PC : (s_style ? BUS_COMBINED : BUS_SEPARATE);
    assign pin_reset_act = s_style ? ~s_rst_pin : s_rst_pin;
    assign rst_any  = srst | pin_reset_act;

    // separate strobes, or read/write line qualified by chip select
    assign host_read = s_style ? (~s_cs_n & s_wr_n) : ~s_rd_n;

    // ------------------------------------------------------------
    // reset release and infrared capture
    // ------------------------------------------------------------
    logic rst_d_ff;
    logic infrared_startup_enable_cap_ff;
    logic ir_sw_ff;
    logic ir_sw_valid_ff;
    logic rst_release;

    assign rst_release = rst_d_ff & ~rst_any;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rst_d_ff <= 1'b1;
        end else begin
            rst_d_ff <= rst_any;
        end
    end

    // strap taken by a clocked process on the release edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            infrared_startup_enable_cap_ff <= 1'b0;
        end else if (rst_release) begin
            infrared_startup_enable_cap_ff <= s_infrared_startup_enable;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            ir_sw_ff       <= 1'b0;
            ir_sw_valid_ff <= 1'b0;
        end else if (sw.write_en) begin
            ir_sw_ff       <= sw.modem_control_register[MCR_IR_BIT];
            ir_sw_valid_ff <= 1'b1;
        end
    end

    // during reset the start-up pin directly decides the idle level, except tx_out under srst
    assign infrared_mode = rst_any ? s_infrared_startup_enable : (ir_sw_valid_ff ? ir_sw_ff : infrared_startup_enable_cap_ff);

    // ------------------------------------------------------------
    // general outputs
    // ------------------------------------------------------------
    logic op1_ff;
    logic op2_ff;

    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            op1_ff <= MCR_RST[MCR_OP1_BIT];
            op2_ff <= MCR_RST[MCR_OP2_BIT];
        end else if (sw.write_en) begin
            op1_ff <= sw.modem_control_register[MCR_OP1_BIT];
            op2_ff <= sw.modem_control_register[MCR_OP2_BIT];
        end
    end

    assign general_output_one_n = ~op1_ff;
    assign general_output_two_n = ~op2_ff;

    // ------------------------------------------------------------
    // drive disable
    // ------------------------------------------------------------
    logic drive_disable_n_n_ff;

    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            drive_disable_n_n_ff <= 1'b1;
        end else begin
            drive_disable_n_n_ff <= ~host_read;
        end
    end

    assign drive_disable_n = drive_disable_n_n_ff;

    // ------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic             baud_tick;
    logic             baud_hi_ff;
    logic [DIV_W-1:0] half_div;

    assign half_div  = div_ff >> 1;
    // a divisor shrunk below the count wraps at once, no long run-out
    assign baud_tick = (cnt_ff >= div_ff - DIV_W'(1));
    assign nxt_cnt   = baud_tick ? '0 : cnt_ff + DIV_W'(1);

    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            div_ff <= DIV_W'(DIV_RST);
        end else if (sw.div_write_en && sw.divisor != '0) begin
            div_ff <= sw.divisor[DIV_W-1:0];
        end
    end

    // reference clock divided down to the 16x rate
    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            cnt_ff     <= '0;
            baud_hi_ff <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            baud_hi_ff <= (nxt_cnt < half_div) || (div_ff == DIV_W'(1) && ~baud_hi_ff);
        end
    end

    // ------------------------------------------------------------
    // baud pin and receive clock steering
    // ------------------------------------------------------------
    logic baud_pin_ff;
    logic rclk_d_ff;
    logic rx_tick_ff;
    logic rx_data_ff;

    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            baud_pin_ff <= 1'b1;
        end else if (pc_mode) begin
            baud_pin_ff <= ~printer_port_one;
        end else begin
            baud_pin_ff <= ~baud_hi_ff;
        end
    end

    assign baud_clock_out_n = baud_pin_ff;

    // rising edge of the synchronised external 16x clock, or the internal baud tick in pc mode
    always_ff @(posedge ref_clk) begin
        if (rst_any) begin
            // tracks the pin in reset so release shows no false edge
            rclk_d_ff  <= s_rclk;
            rx_tick_ff <= 1'b0;
            rx_data_ff <= 1'b1;
        end else begin
            rclk_d_ff  <= s_rclk;
            rx_tick_ff <= pc_mode ? baud_tick : (s_rclk & ~rclk_d_ff);
            rx_data_ff <= s_rx;
        end
    end

    // receive input ignored while in reset
    assign rx_sample_tick = rx_tick_ff & ~rst_any;
    assign rx_data        = rst_any ? (infrared_mode ? TX_IDLE_IR : TX_IDLE_NORMAL) : rx_data_ff;

    // ------------------------------------------------------------
    // transmit output
    // ------------------------------------------------------------
    logic tx_ff;
    logic tx_idle;

    assign tx_idle = infrared_mode ? TX_IDLE_IR : TX_IDLE_NORMAL;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_ff <= TX_IDLE_NORMAL;
        end else if (rst_any) begin
            tx_ff <= tx_idle;
        end else begin
            tx_ff <= tx_active ? tx_data : tx_idle;
        end
    end

    assign tx_out        = tx_ff;
    assign ref_clock_out = ref_clk;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DRIVE_DISABLE_N_READ: assert property (@(posedge ref_clk) disable iff (rst_any)
        host_read |=> !drive_disable_n)
        else $error("drive disable not low in read");
    AST_DRIVE_DISABLE_N_IDLE: assert property (@(posedge ref_clk) disable iff (rst_any)
        !host_read |=> drive_disable_n)
        else $error("drive disable low outside read");
    AST_IR_CAPTURE: assert property (@(posedge ref_clk) disable iff (srst)
        rst_release |=> infrared_startup_enable_cap_ff == $past(s_infrared_startup_enable))
        else $error("start-up capture wrong");
    AST_TX_IDLE: assert property (@(posedge ref_clk) disable iff (srst)
        (!rst_any && !tx_active) |=> tx_out == $past(tx_idle))
        else $error("tx idle level wrong");
    AST_SW_OVERRIDE: assert property (@(posedge ref_clk) disable iff (rst_any)
        sw.write_en |=> infrared_mode == $past(sw.modem_control_register[MCR_IR_BIT]))
        else $error("ir override lost");
    AST_RESET_OUT: assert property (@(posedge ref_clk)
        srst |=> (drive_disable_n && general_output_one_n && general_output_two_n && baud_clock_out_n))
        else $error("outputs not at reset value");
    AST_RX_IGNORE: assert property (@(posedge ref_clk)
        rst_any |-> !rx_sample_tick ##1 !rx_tick_ff)
        else $error("receive tick in reset");
    AST_TX_RESET: assert property (@(posedge ref_clk) disable iff (srst)
        (rst_any && !srst) |=> tx_out == $past(tx_idle))
        else $error("tx not held at idle in reset");
    AST_PC_DECODE: assert property (@(posedge ref_clk) disable iff (rst_any)
        pc_mode |=> baud_clock_out_n == !$past(printer_port_one))
        else $error("printer decode not on baud pin");
    AST_POLARITY: assert property (@(posedge ref_clk)
        (s_style && !s_rst_pin) |-> rst_any)
        else $error("low reset ignored in combined style");
    AST_GP_OUT: assert property (@(posedge ref_clk) disable iff (rst_any)
        sw.write_en |=> general_output_one_n == !$past(sw.modem_control_register[MCR_OP1_BIT]))
        else $error("op1 wrong");
    AST_EXT_TICK: assert property (@(posedge ref_clk) disable iff (rst_any)
        (!pc_mode && s_rclk && !rclk_d_ff) |=> rx_sample_tick)
        else $error("external clock edge gave no tick");
    AST_DIV_REFUSE: assert property (@(posedge ref_clk) disable iff (rst_any)
        (sw.div_write_en && sw.divisor == '0) |=> $stable(div_ff))
        else $error("zero divisor taken");
    AST_BAUD_WRAP: assert property (@(posedge ref_clk) disable iff (rst_any)
        (cnt_ff >= div_ff) |=> cnt_ff == '0)
        else $error("baud counter ran past divisor");
endmodule

// ===== testbench/host_model.sv
// host processor model driving the strobes and software control
`timescale 1ns/1ps
module host_model
    import pin_ctrl_pkg::*;
(
    // clock
    input  wire logic   ref_clk,
    // host bus side
    output sw_ctrl_type sw,
    output logic        read_strobe_n,
    output logic        write_strobe_n,
    output logic        chip_select_n
);
    initial begin
        read_strobe_n  = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_n  = 1'b1;
        sw             = '0;
        sw.divisor     = 16'h0001;
    end
    // read held n cycles; released only at an edge, never mid-cycle
    task automatic host_read(input int n);
        @(posedge ref_clk);
        chip_select_n <= 1'b0;
        read_strobe_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        chip_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
    endtask
    // write cycle: chip select with write strobe low
    task automatic host_write(input int n);
        @(posedge ref_clk);
        chip_select_n  <= 1'b0;
        write_strobe_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        chip_select_n  <= 1'b1;
        write_strobe_n <= 1'b1;
    endtask
    // single-cycle divisor load; zero is refused by the block
    task automatic write_div(input logic [15:0] v);
        @(posedge ref_clk);
        sw.div_write_en <= 1'b1;
        sw.divisor      <= v;
        @(posedge ref_clk);
        sw.div_write_en <= 1'b0;
    endtask
    // single-cycle load pulse, taken on the edge it is high
    task automatic write_mcr(input logic [7:0] v);
        @(posedge ref_clk);
        sw.write_en <= 1'b1;
        sw.modem_control_register      <= v;
        @(posedge ref_clk);
        sw.write_en <= 1'b0;
    endtask
endmodule

// ===== testbench/uart_mode_reset_clock_pins_test.sv
// self-checking bench for the serial port pin control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module uart_mode_reset_clock_pins_test;
    import pin_ctrl_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    logic         reset_pin = 1'b0;
    // separate strobes, not pc mode, receive clock low, rx idle high
    pins_in_type  pins = 5'h09;
    logic         printer_port_one = 1'b0;
    logic         tx_data = 1'b1;
    logic         tx_active = 1'b0;
    logic         loop_back = 1'b0;
    sw_ctrl_type  sw;
    logic         rd_n, wr_n, cs_n;
    logic         ck_out, baud_n, drive_disable_n_n, op1_n, op2_n, tx_out, tick, rx_data, dec_en, ir;
    bus_mode_type bus_mode;
    int           n_mismatch = 0;
    int           n_tests = 0;
    int           n_tick = 0;
    int           n_baud = 0;
    always #12.5 ref_clk = ~ref_clk;
    // counted on the falling edge, clear of the launching edge
    always @(negedge ref_clk) begin
        if (tick === 1'b1) n_tick++;
        if ($fell(baud_n)) n_baud++;
    end
    // board wiring of the baud clock pin back into the receive clock
    always @(posedge ref_clk) begin
        if (loop_back) pins.rclk <= baud_n;
    end
    host_model i_host (.ref_clk(ref_clk), .sw(sw), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .chip_select_n(cs_n));
    uart_mode_reset_clock_pins i_dut (.ref_clk(ref_clk), .srst(srst), .reset_pin(reset_pin), .pins(pins),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chip_select_n(cs_n), .printer_port_one(printer_port_one),
        .sw(sw), .tx_data(tx_data), .tx_active(tx_active), .ref_clock_out(ck_out), .baud_clock_out_n(baud_n),
        .drive_disable_n(drive_disable_n_n), .general_output_one_n(op1_n), .general_output_two_n(op2_n),
        .tx_out(tx_out), .rx_sample_tick(tick), .rx_data(rx_data), .onchip_decode_en(dec_en),
        .infrared_mode(ir), .bus_mode(bus_mode));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read;
        int i;
        fork
            i_host.host_read(8);
            begin
                for (i = 0; i < 8 && drive_disable_n_n !== 1'b0; i++) step(1);
                if (i == 8) begin n_mismatch++; $display("[FAIL] drive_disable_n timeout"); wrap_up(); end
                repeat (4) begin step(1); `CHK("drive_disable_n_low", 1'b0, drive_disable_n_n) end
            end
        join
        step(5);
        `CHK("drive_disable_n_high", 1'b1, drive_disable_n_n)
        fork
            i_host.host_write(8);
            begin step(6); `CHK("sep_write", 1'b1, drive_disable_n_n) end
        join
        $display("t_read done");
    endtask
    task automatic t_gpo;
        i_host.write_mcr(8'h0C);
        step(2);
        `CHK("op1_low", 1'b0, op1_n)
        `CHK("op2_low", 1'b0, op2_n)
        i_host.write_mcr(8'h04);
        step(2);
        `CHK("op2_high", 1'b1, op2_n)
        $display("t_gpo done");
    endtask
    task automatic t_ir;
        @(posedge ref_clk) pins.infrared_startup_enable <= 1'b1;
        step(4);
        @(posedge ref_clk) reset_pin <= 1'b1;
        step(4);
        @(posedge ref_clk) reset_pin <= 1'b0;
        step(6);
        `CHK("ir_strap", 1'b1, ir)
        `CHK("tx_idle_ir", TX_IDLE_IR, tx_out)
        `CHK("op1_reset", 1'b1, op1_n)
        @(posedge ref_clk) pins.infrared_startup_enable <= 1'b0;
        i_host.write_mcr(8'h00);
        step(3);
        `CHK("ir_sw_off", 1'b0, ir)
        `CHK("tx_idle_norm", TX_IDLE_NORMAL, tx_out)
        i_host.write_mcr(8'h40);
        step(3);
        `CHK("ir_sw_on", 1'b1, ir)
        i_host.write_mcr(8'h00);
        $display("t_ir done");
    endtask
    task automatic t_polarity;
        // low-active reset here: pin goes high in the same cycle that the style flips
        @(posedge ref_clk) reset_pin <= 1'b1;
        pins.bus_style_select <= 1'b1;
        step(6);
        `CHK("bus_comb", BUS_COMBINED, bus_mode)
        fork
            i_host.host_read(8);
            begin step(6); `CHK("comb_read", 1'b0, drive_disable_n_n) end
        join
        fork
            i_host.host_write(8);
            begin step(6); `CHK("comb_write", 1'b1, drive_disable_n_n) end
        join
        i_host.write_mcr(8'h04);
        step(2);
        `CHK("op1_set", 1'b0, op1_n)
        @(posedge ref_clk) reset_pin <= 1'b0;
        step(6);
        `CHK("op1_rst_low", 1'b1, op1_n)
        @(posedge ref_clk) pins.bus_style_select <= 1'b0;
        step(6);
        `CHK("bus_sep", BUS_SEPARATE, bus_mode)
        $display("t_polarity done");
    endtask
    task automatic t_pc;
        @(posedge ref_clk) pins.pc_decode_select_n <= 1'b0;
        step(5);
        `CHK("dec_en", 1'b1, dec_en)
        `CHK("bus_pc", BUS_PC, bus_mode)
        @(posedge ref_clk) printer_port_one <= 1'b1;
        step(2);
        `CHK("lpt_on", 1'b0, baud_n)
        @(posedge ref_clk) printer_port_one <= 1'b0;
        n_tick = 0;
        step(64);
        `CHK("lpt_off", 1'b1, baud_n)
        `CHK("int_ticks", 64 / int'(DIV_RST), n_tick)
        @(posedge ref_clk) pins.pc_decode_select_n <= 1'b1;
        step(5);
        `CHK("dec_off", 1'b0, dec_en)
        $display("t_pc done");
    endtask
    task automatic t_rclk;
        n_tick = 0;
        n_baud = 0;
        repeat (4) begin
            @(posedge ref_clk) pins.rclk <= 1'b1;
            step(3);
            @(posedge ref_clk) pins.rclk <= 1'b0;
            step(3);
        end
        step(6);
        `CHK("ext_ticks", 4, n_tick)
        `CHK("baud_runs", 1'b1, n_baud > 0)
        $display("t_rclk done");
    endtask
    task automatic t_baud;
        i_host.write_div(16'h0004);
        step(8);
        n_baud = 0;
        step(32);
        `CHK("baud_div4", 8, n_baud)
        i_host.write_div(16'h0000);
        step(8);
        n_baud = 0;
        step(32);
        `CHK("baud_div0", 8, n_baud)
        @(posedge ref_clk) loop_back <= 1'b1;
        step(8);
        n_tick = 0;
        step(32);
        `CHK("loop_ticks", 8, n_tick)
        @(posedge ref_clk) loop_back <= 1'b0;
        @(posedge ref_clk) pins.rclk <= 1'b0;
        i_host.write_div(16'h0002);
        step(8);
        n_baud = 0;
        step(32);
        `CHK("baud_div2", 16, n_baud)
        $display("t_baud done");
    endtask
    task automatic t_rx;
        @(posedge ref_clk) pins.rx <= 1'b0;
        tx_active <= 1'b1;
        tx_data   <= 1'b0;
        step(4);
        `CHK("rx_pass", 1'b0, rx_data)
        `CHK("tx_data", 1'b0, tx_out)
        @(posedge ref_clk) reset_pin <= 1'b1;
        pins.rclk <= 1'b1;
        n_tick = 0;
        step(4);
        `CHK("rx_ignored", 1'b1, rx_data)
        `CHK("tx_held", 1'b1, tx_out)
        `CHK("rst_ticks", 0, n_tick)
        @(posedge ref_clk) reset_pin <= 1'b0;
        pins.rx   <= 1'b1;
        pins.rclk <= 1'b0;
        tx_active <= 1'b0;
        step(6);
        `CHK("tx_idle", TX_IDLE_NORMAL, tx_out)
        $display("t_rx done");
    endtask
    initial begin
        step(2);
        `CHK("rst_drive_disable_n", 1'b1, drive_disable_n_n)
        `CHK("rst_op2", 1'b1, op2_n)
        `CHK("rst_tx", 1'b1, tx_out)
        `CHK("rst_tick", 1'b0, tick)
        @(posedge ref_clk) srst <= 1'b0;
        step(4);
        t_read();
        t_gpo();
        t_ir();
        t_polarity();
        t_pc();
        t_rclk();
        t_baud();
        t_rx();
        wrap_up();
    end
endmodule
